// ### hw/qpd_device.sv
/*
  Quad pot serial command decoder: identification check, instruction
  decode, wiper and stored-setting registers, step stream, write-busy
  timer.
  Assumes link pins arrive asynchronously and sck is slow enough for
  the 100 MHz clock to see each level for several cycles.
*/
// Functional notes
// - Second byte: opcode, register select, pot select
// - Register select picks stored setting register
// - Pot select picks affected potentiometer
// - Copies act after instruction byte completes
// - Opcode 1101 loads wiper from stored setting
// - Opcode 1110 saves wiper into stored setting
// - Opcode 0001 loads all wipers globally
// - Opcode 1000 saves all wipers globally
// - Five commands carry one data byte
// - Opcode 1001 returns wiper position
// - Opcode 1010 writes wiper position
// - Opcode 1011 returns stored setting
// - Opcode 1100 writes stored setting
// - Byte 0x51 returns write busy status
// - Opcode 0010 opens unbounded step stream
// - Each pulse steps wiper by input level
// - Save starts on chip select rising
// - Address bits must match address pins
// - Write protect low blocks all saves
// - Busy flag held for save time
`timescale 1ns/100ps
module qpd_device #(
  parameter logic [3:0] DEV_TYPE        = 4'h9, // Arbitrary type code
  parameter int         NV_WRITE_CYCLES = qpd_pkg::NV_WRITE_CYCLES
) (
  input  wire logic            mclk_in,
  input  wire logic            reset_n_in,
  qpd_spi_if.device            link,
  input  wire logic [1:0]      dev_addr_in,
  input  wire logic            write_prot_n_in,
  output logic      [3:0][7:0] wiper_out,
  output logic                 write_busy_out
);

  localparam int BW = qpd_pkg::BUSY_W;

  typedef struct packed {
    logic [1:0]           sck_sy;
    logic                 sck_last;
    logic [1:0]           cs_sy;
    logic                 cs_last;
    logic [1:0]           si_sy;
    logic [1:0][1:0]      addr_sy;
    logic [1:0]           wp_sy;
    qpd_pkg::qpd_dst_e    st;
    logic [2:0]           bcnt;
    logic [7:0]           rx;
    logic [3:0]           op;
    logic [1:0]           rsel;
    logic [1:0]           psel;
    logic [7:0]           tx;
    logic                 so;
    logic                 so_oe;
    logic [3:0][7:0]      wiper;
    logic [3:0][3:0][7:0] store;
    logic                 nv_pend;
    logic                 nv_glob;
    logic [7:0]           nv_data;
    logic [BW-1:0]        busy_cnt;
  } qpd_dev_s;

  qpd_dev_s q;
  qpd_dev_s d;

  logic       rise;
  logic       fall;
  logic       cs_act;
  logic       cs_rise;
  logic       bit_in;
  logic       last;
  logic       nv_ok;
  logic       busy;
  logic [7:0] byte_v;
  logic [3:0] b_op;
  logic [1:0] b_r;
  logic [1:0] b_p;

  // ----------------------------------------------------------------
  // Link sampling and event decode
  // ----------------------------------------------------------------
  always_comb begin
    rise    = q.sck_sy[1] & ~q.sck_last;
    fall    = ~q.sck_sy[1] & q.sck_last;
    cs_act  = ~q.cs_sy[1];
    cs_rise = q.cs_sy[1] & ~q.cs_last;
    bit_in  = q.si_sy[1];
    byte_v  = {q.rx[6:0], bit_in};
    last    = (q.bcnt == 3'h7);
    b_op    = byte_v[qpd_pkg::OP_MSB:qpd_pkg::OP_LSB];
    b_r     = byte_v[qpd_pkg::RSEL_MSB:qpd_pkg::RSEL_LSB];
    b_p     = byte_v[qpd_pkg::PSEL_MSB:qpd_pkg::PSEL_LSB];
    busy    = (q.busy_cnt != '0);
    nv_ok   = q.wp_sy[1] & ~busy;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.sck_sy   = {q.sck_sy[0], link.sck};
    d.sck_last = q.sck_sy[1];
    d.cs_sy    = {q.cs_sy[0], link.cs_n};
    d.cs_last  = q.cs_sy[1];
    d.si_sy    = {q.si_sy[0], link.si};
    d.addr_sy  = {q.addr_sy[0], dev_addr_in};
    d.wp_sy    = {q.wp_sy[0], write_prot_n_in};

    // Busy timer for the nonvolatile save
    if (busy) begin
      d.busy_cnt = q.busy_cnt - BW'(1);
    end

    if (!cs_act) begin
      // Frame closed: rearm, release the output, launch a save
      d.st    = qpd_pkg::DS_ID;
      d.bcnt  = 3'h0;
      d.so_oe = 1'b0;
      if (cs_rise && q.nv_pend) begin
        for (int p = 0; p < 4; p++) begin
          if (q.nv_glob) begin
            d.store[p][q.rsel] = q.wiper[p];
          end
        end
        if (!q.nv_glob) begin
          d.store[q.psel][q.rsel] = q.nv_data;
        end
        d.busy_cnt = BW'(NV_WRITE_CYCLES);
      end
      d.nv_pend = 1'b0;
    end else if (rise) begin
      d.rx   = byte_v;
      d.bcnt = q.bcnt + 3'h1;
      case (q.st)
        qpd_pkg::DS_ID: begin
          if (last) begin
            if (byte_v[7:4] == DEV_TYPE && byte_v[3:2] == 2'h0 &&
                byte_v[1:0] == q.addr_sy[1]) begin
              d.st = qpd_pkg::DS_INSTR;
            end else begin
              d.st = qpd_pkg::DS_SKIP;
            end
          end
        end
        qpd_pkg::DS_INSTR: begin
          if (last) begin
            d.op   = b_op;
            d.rsel = b_r;
            d.psel = b_p;
            d.st   = qpd_pkg::DS_SKIP;
            case (b_op)
              qpd_pkg::OP_COPY_S2W: begin
                d.wiper[b_p] = q.store[b_p][b_r];
              end
              qpd_pkg::OP_COPY_W2S: begin
                d.nv_pend = nv_ok;
                d.nv_glob = 1'b0;
                d.nv_data = q.wiper[b_p];
              end
              qpd_pkg::OP_GCOPY_S2W: begin
                if (b_p == 2'h0) begin
                  for (int p = 0; p < 4; p++) begin
                    d.wiper[p] = q.store[p][b_r];
                  end
                end
              end
              qpd_pkg::OP_GCOPY_W2S: begin
                d.nv_pend = nv_ok && (b_p == 2'h0);
                d.nv_glob = 1'b1;
              end
              qpd_pkg::OP_RD_WIPER: begin
                if (b_r == 2'h0) begin
                  d.tx    = q.wiper[b_p];
                  d.so    = q.wiper[b_p][7];
                  d.so_oe = 1'b1;
                  d.st    = qpd_pkg::DS_RD;
                end
              end
              qpd_pkg::OP_WR_WIPER: begin
                if (b_r == 2'h0) begin
                  d.st = qpd_pkg::DS_WR;
                end
              end
              qpd_pkg::OP_RD_STORE: begin
                d.tx    = q.store[b_p][b_r];
                d.so    = q.store[b_p][b_r][7];
                d.so_oe = 1'b1;
                d.st    = qpd_pkg::DS_RD;
              end
              qpd_pkg::OP_WR_STORE: d.st = qpd_pkg::DS_WR;
              qpd_pkg::OP_STEP: begin
                if (b_r == 2'h0) begin
                  d.st = qpd_pkg::DS_STEP;
                end
              end
              qpd_pkg::OP_STATUS: begin
                if (byte_v == qpd_pkg::STATUS_INSTR) begin
                  d.tx    = {7'h00, busy};
                  d.so    = 1'b0;
                  d.so_oe = 1'b1;
                  d.st    = qpd_pkg::DS_RD;
                end
              end
              default: d.st = qpd_pkg::DS_SKIP;
            endcase
          end
        end
        qpd_pkg::DS_WR: begin
          if (last) begin
            d.st = qpd_pkg::DS_SKIP;
            if (q.op == qpd_pkg::OP_WR_WIPER) begin
              d.wiper[q.psel] = byte_v;
            end else begin
              d.nv_pend = nv_ok;
              d.nv_glob = 1'b0;
              d.nv_data = byte_v;
            end
          end
        end
        qpd_pkg::DS_RD: begin
          if (last) begin
            d.st    = qpd_pkg::DS_SKIP;
            d.so_oe = 1'b0;
          end
        end
        qpd_pkg::DS_STEP: begin
          // One step per pulse, held at the end taps
          if (bit_in && q.wiper[q.psel] != 8'hff) begin
            d.wiper[q.psel] = q.wiper[q.psel] + 8'h01;
          end else if (!bit_in && q.wiper[q.psel] != 8'h00) begin
            d.wiper[q.psel] = q.wiper[q.psel] - 8'h01;
          end
        end
        default: d.st = qpd_pkg::DS_SKIP;
      endcase
    end else if (fall && q.st == qpd_pkg::DS_RD && q.bcnt != 3'h0) begin
      // Next bit out after each falling edge inside the read byte
      d.tx = {q.tx[6:0], 1'b0};
      d.so = q.tx[6];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q          <= '0;
      q.cs_sy    <= 2'h3;
      q.cs_last  <= 1'b1;
      q.st       <= qpd_pkg::DS_ID;
      q.so       <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign link.so_drv    = q.so;
  assign link.so_oe     = q.so_oe;
  assign wiper_out      = q.wiper;
  assign write_busy_out = (q.busy_cnt != '0);

endmodule : qpd_device

// ### hw/qpd_pkg.sv
/*
  Shared constants for the quad pot serial command decoder and its
  host controller: opcodes, frame lengths, state codes, timing and the
  host's register map.
  Assumes a 100 MHz system clock on both ends.
*/
package qpd_pkg;

  // ----------------------------------------------------------------
  // Instruction byte layout and opcodes
  // ----------------------------------------------------------------
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int RSEL_MSB = 3;
  localparam int RSEL_LSB = 2;
  localparam int PSEL_MSB = 1;
  localparam int PSEL_LSB = 0;

  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'ha;
  localparam logic [3:0] OP_RD_STORE  = 4'hb;
  localparam logic [3:0] OP_WR_STORE  = 4'hc;
  localparam logic [3:0] OP_COPY_S2W  = 4'hd;
  localparam logic [3:0] OP_COPY_W2S  = 4'he;
  localparam logic [3:0] OP_GCOPY_S2W = 4'h1;
  localparam logic [3:0] OP_GCOPY_W2S = 4'h8;
  localparam logic [3:0] OP_STEP      = 4'h2;
  localparam logic [3:0] OP_STATUS    = 4'h5;
  localparam logic [7:0] STATUS_INSTR = 8'h51;

  // ----------------------------------------------------------------
  // Frame lengths in serial clock pulses
  // ----------------------------------------------------------------
  localparam logic [8:0] FRAME_SHORT = 9'h010;
  localparam logic [8:0] FRAME_LONG  = 9'h018;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ   = 100000;
  localparam int NV_WRITE_MS    = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLK_FREQ_KHZ;
  localparam int BUSY_W         = 20;
  localparam int SCK_HALF_CYCLES = 4;

  // ----------------------------------------------------------------
  // Device receive states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    DS_ID    = 6'h01,
    DS_INSTR = 6'h02,
    DS_WR    = 6'h04,
    DS_RD    = 6'h08,
    DS_STEP  = 6'h10,
    DS_SKIP  = 6'h20
  } qpd_dst_e;

  // ----------------------------------------------------------------
  // Host states and register map
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_LOW  = 4'h2,
    HS_HIGH = 4'h4,
    HS_END  = 4'h8
  } qpd_hst_e;

  localparam logic [3:0] REG_CFG  = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_CMD  = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;

endpackage : qpd_pkg

// ### hw/qpd_spi_if.sv
/*
  Serial link between the pot command decoder and its host.
  The serial output is pulled high whenever the device does not drive it.
*/
`timescale 1ns/100ps
interface qpd_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_drv;
  logic so_oe;
  logic so;

  // Resolve the shared serial output wire
  assign so = so_oe ? so_drv : 1'b1;

  modport device (input cs_n, input sck, input si,
                  output so_drv, output so_oe);
  modport host   (output cs_n, output sck, output si, input so);
endinterface : qpd_spi_if

// ### hw/qpd_host.sv
/*
  Host controller for the quad pot serial link: register port for
  software, frame builder and serial clock divider.
  Assumes one command at a time; commands written while busy are dropped.
*/
`timescale 1ns/100ps
module qpd_host #(
  parameter logic [3:0] DEV_TYPE = 4'h9, // Arbitrary type code
  parameter int         HALF     = qpd_pkg::SCK_HALF_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  qpd_spi_if.host          link
);

  typedef struct packed {
    qpd_pkg::qpd_hst_e st;
    logic [7:0]        div;
    logic [8:0]        bidx;
    logic [8:0]        nbits;
    logic [23:0]       tx;
    logic [7:0]        rx;
    logic [1:0]        so_sy;
    logic              cs_n;
    logic              sck;
    logic              si;
    logic [1:0]        dev_addr;
    logic [7:0]        data;
    logic [7:0]        steps;
    logic              dir;
    logic              step;
    logic [31:0]       rdata;
  } qpd_host_s;

  qpd_host_s q;
  qpd_host_s d;
  logic      tick;
  logic [3:0] op;

  // ----------------------------------------------------------------
  // Register port, frame builder and clock divider
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.so_sy = {q.so_sy[0], link.so};
    tick    = (q.div == 8'(HALF - 1));
    op      = reg_wdata_in[7:4];
    d.div   = tick ? 8'h00 : q.div + 8'h01;
    d.rdata = 32'h0;

    // Register reads, answered next cycle
    if (reg_rd_in) begin
      case (reg_addr_in)
        qpd_pkg::REG_CFG:  d.rdata = {30'h0, q.dev_addr};
        qpd_pkg::REG_DATA: d.rdata = {15'h0, q.dir, q.steps, q.data};
        qpd_pkg::REG_STAT: d.rdata = {16'h0, q.rx, 7'h00,
                                      q.st != qpd_pkg::HS_IDLE};
        default:           d.rdata = 32'h0;
      endcase
    end

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        qpd_pkg::REG_CFG: d.dev_addr = reg_wdata_in[1:0];
        qpd_pkg::REG_DATA: begin
          d.data  = reg_wdata_in[7:0];
          d.steps = reg_wdata_in[15:8];
          d.dir   = reg_wdata_in[16];
        end
        qpd_pkg::REG_CMD: begin
          if (q.st == qpd_pkg::HS_IDLE) begin
            // Frame length follows the opcode
            case (op)
              qpd_pkg::OP_RD_WIPER, qpd_pkg::OP_WR_WIPER,
              qpd_pkg::OP_RD_STORE, qpd_pkg::OP_WR_STORE,
              qpd_pkg::OP_STATUS: d.nbits = qpd_pkg::FRAME_LONG;
              qpd_pkg::OP_STEP:   d.nbits = qpd_pkg::FRAME_SHORT +
                                            {1'b0, q.steps};
              default:            d.nbits = qpd_pkg::FRAME_SHORT;
            endcase
            d.tx   = {DEV_TYPE, 2'h0, q.dev_addr,
                      reg_wdata_in[7:0], q.data};
            d.si   = DEV_TYPE[3];
            d.cs_n = 1'b0;
            d.sck  = 1'b0;
            d.bidx = 9'h000;
            d.div  = 8'h00;
            d.st   = qpd_pkg::HS_LOW;
            // Remember the stream kind; tx shifts the opcode away
            d.step = (op == qpd_pkg::OP_STEP);
          end
        end
        default: begin
          d.st = q.st;
        end
      endcase
    end

    // Serial clock sequencing
    case (q.st)
      qpd_pkg::HS_IDLE: begin
        d.cs_n = (reg_wr_in && reg_addr_in == qpd_pkg::REG_CMD) ?
                 d.cs_n : 1'b1;
      end
      qpd_pkg::HS_LOW: begin
        if (tick) begin
          d.sck = 1'b1;
          d.st  = qpd_pkg::HS_HIGH;
        end
      end
      qpd_pkg::HS_HIGH: begin
        if (tick) begin
          d.sck  = 1'b0;
          d.bidx = q.bidx + 9'h001;
          if (q.bidx >= qpd_pkg::FRAME_SHORT) begin
            d.rx = {q.rx[6:0], q.so_sy[1]};
          end
          d.tx = {q.tx[22:0], 1'b0};
          if (q.bidx + 9'h001 >= qpd_pkg::FRAME_SHORT &&
              q.step) begin
            d.si = q.dir;
          end else begin
            d.si = q.tx[22];
          end
          if (q.bidx + 9'h001 == q.nbits) begin
            d.st = qpd_pkg::HS_END;
          end else begin
            d.st = qpd_pkg::HS_LOW;
          end
        end
      end
      qpd_pkg::HS_END: begin
        if (tick) begin
          d.cs_n = 1'b1;
          d.st   = qpd_pkg::HS_IDLE;
        end
      end
      default: begin
        d.st = qpd_pkg::HS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q       <= '0;
      q.st    <= qpd_pkg::HS_IDLE;
      q.cs_n  <= 1'b1;
      q.so_sy <= 2'h3;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign link.cs_n     = q.cs_n;
  assign link.sck      = q.sck;
  assign link.si       = q.si;
  assign reg_rdata_out = q.rdata;

endmodule : qpd_host

// ### dv/qpd_link_asserts.sv
/*
  Checker for the pot serial link: framing, serial clock shape, data
  hold, serial output enable and write-busy timing.
  Assumes the host divider gives four clocks per serial clock phase.
*/
`timescale 1ns/100ps
module qpd_link_asserts #(
  parameter int NV = 50
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic so_oe_in,
  input wire logic busy_in
);
  // ----
  // Busy length counter
  // ----
  int busy_cnt_q;

  // Counts the cycles of one busy period
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_in ? busy_cnt_q + 1 : 0;
  end

  default clocking dck @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  // Link properties
  AST_OE_IN_FRAME: assert property (so_oe_in |-> !cs_n_in)
    else $error("serial output driven outside a frame");
  AST_SCK_IDLE: assert property (
    cs_n_in && $past(cs_n_in) |-> !sck_in)
    else $error("serial clock moves outside a frame");
  AST_SCK_HIGH: assert property (
    $rose(sck_in) |-> sck_in[*4] ##1 !sck_in)
    else $error("serial clock high phase wrong");
  AST_SCK_LOW: assert property ($fell(sck_in) |-> !sck_in[*4])
    else $error("serial clock low phase too short");
  AST_FRAME_START: assert property ($fell(cs_n_in) |-> !sck_in[*3])
    else $error("frame opens with clock high");
  AST_SI_HOLD: assert property (
    $rose(sck_in) |-> $stable(si_in)[*4])
    else $error("serial input moves while clock high");
  AST_OE_HOLD: assert property ($rose(so_oe_in) |-> so_oe_in[*8])
    else $error("serial output enable too short");
  AST_BUSY_START: assert property (
    $rose(busy_in) |-> cs_n_in && $past(cs_n_in))
    else $error("save started inside a frame");
  AST_BUSY_LEN: assert property (
    $fell(busy_in) |-> busy_cnt_q >= NV - 1 && busy_cnt_q <= NV + 1)
    else $error("busy period length wrong");
  AST_FRAME_END: assert property (
    $rose(cs_n_in) |-> !so_oe_in && !sck_in)
    else $error("frame closed while active");
endmodule : qpd_link_asserts

// ### dv/qpd_tb.sv
/*
  Self-checking bench: host and device joined by one link, a byte model
  of wipers and stored settings, random data from a fixed seed.
  Assumes the host register map and step fields of the package.
*/
`timescale 1ns/100ps
module quad_pot_spi_command_decoder_tb;
  localparam int NV = 400;
  logic            mclk;
  logic            reset_n;
  logic [3:0]      reg_addr;
  logic [31:0]     reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [31:0]     reg_rdata;
  logic [1:0]      dev_addr;
  logic            wp_n;
  logic [3:0][7:0] wipers;
  logic            busy;
  logic [7:0]      m_wip [4];
  logic [7:0]      m_sto [4][4];
  logic [7:0]      rx;
  logic [7:0]      d;
  logic [1:0]      r;
  logic [31:0]     w;
  logic [3:0]      bad [6] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'hf};
  int              error_cnt = 0;
  int              checked = 0;
  int              cyc = 0;

  qpd_spi_if link_if ();
  qpd_host qpd_host_inst (.mclk_in(mclk), .reset_n_in(reset_n),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .link(link_if.host));
  qpd_device #(.NV_WRITE_CYCLES(NV)) qpd_device_inst (.mclk_in(mclk),
    .reset_n_in(reset_n), .link(link_if.device), .dev_addr_in(dev_addr),
    .write_prot_n_in(wp_n), .wiper_out(wipers), .write_busy_out(busy));
  qpd_link_asserts #(.NV(NV)) qpd_link_asserts_inst (.mclk_in(mclk),
    .reset_n_in(reset_n), .cs_n_in(link_if.cs_n), .sck_in(link_if.sck),
    .si_in(link_if.si), .so_oe_in(link_if.so_oe), .busy_in(busy));

  // ----
  // Clock, timeout and bus tasks
  // ----
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // One whole frame: data, command, poll until the host is idle
  task automatic run(input logic [7:0] ins, input logic [31:0] dat,
                     output logic [7:0] got);
    logic [31:0] s;
    wr(qpd_pkg::REG_DATA, dat);
    wr(qpd_pkg::REG_CMD, {24'h0, ins});
    repeat (2) @(posedge mclk);
    s = 32'h1;
    for (int n = 0; n < 800 && s[0] !== 1'b0; n++) rd(qpd_pkg::REG_STAT, s);
    if (s[0] !== 1'b0) begin
      error_cnt++;
      $display("wrong value at %0t: host never went idle", $time);
    end
    repeat (8) @(posedge mclk);
    got = s[15:8];
  endtask : run

  task automatic wait_idle();
    for (int n = 0; n < 600 && busy !== 1'b0; n++) @(posedge mclk);
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("wrong value at %0t: save never finished", $time);
    end
  endtask : wait_idle

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_wipers();
    for (int q = 0; q < 4; q++) chk_byte(wipers[q], m_wip[q]);
  endtask : chk_wipers

  task automatic give_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // ----
  // Main sequence
  // ----
  initial begin
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dev_addr = 2'h2;
    wp_n = 1'b1;
    foreach (m_sto[p, q]) m_sto[p][q] = 8'h00;
    foreach (m_wip[p]) m_wip[p] = 8'h00;
    void'($urandom(425));
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    wr(qpd_pkg::REG_CFG, 32'h2);
    // Direct wiper writes and reads on every pot
    for (int p = 0; p < 4; p++) begin
      d = 8'($urandom);
      run({qpd_pkg::OP_WR_WIPER, 2'b00, 2'(p)}, {24'h0, d}, rx);
      m_wip[p] = d;
    end
    chk_wipers();
    for (int p = 0; p < 4; p++) begin
      run({qpd_pkg::OP_RD_WIPER, 2'b00, 2'(p)}, 32'h0, rx);
      chk_byte(rx, m_wip[p]);
    end
    // Stored setting write, busy status, read back
    for (int p = 0; p < 4; p++) begin
      r = 2'($urandom);
      d = 8'($urandom);
      run({qpd_pkg::OP_WR_STORE, r, 2'(p)}, {24'h0, d}, rx);
      m_sto[p][r] = d;
      run(qpd_pkg::STATUS_INSTR, 32'h0, rx);
      chk_byte(rx, 8'h01);
      wait_idle();
      run(qpd_pkg::STATUS_INSTR, 32'h0, rx);
      chk_byte(rx, 8'h00);
      run({qpd_pkg::OP_RD_STORE, r, 2'(p)}, 32'h0, rx);
      chk_byte(rx, m_sto[p][r]);
    end
    // Single copies both ways on pot 2
    r = 2'($urandom);
    run({qpd_pkg::OP_COPY_W2S, r, 2'd2}, 32'h0, rx);
    m_sto[2][r] = m_wip[2];
    wait_idle();
    run({qpd_pkg::OP_WR_WIPER, 4'h2}, {24'h0, ~m_wip[2]}, rx);
    run({qpd_pkg::OP_COPY_S2W, r, 2'd2}, 32'h0, rx);
    chk_wipers();
    // Global copies both ways
    r = 2'($urandom);
    run({qpd_pkg::OP_GCOPY_W2S, r, 2'b00}, 32'h0, rx);
    for (int q = 0; q < 4; q++) m_sto[q][r] = m_wip[q];
    wait_idle();
    for (int q = 0; q < 4; q++) begin
      run({qpd_pkg::OP_WR_WIPER, 2'b00, 2'(q)}, {24'h0, ~m_wip[q]}, rx);
    end
    run({qpd_pkg::OP_GCOPY_S2W, r, 2'b00}, 32'h0, rx);
    chk_wipers();
    // Step stream up and down past both ends, then a random count up
    run({qpd_pkg::OP_WR_WIPER, 4'h1}, 32'h00fd, rx);
    run({qpd_pkg::OP_STEP, 4'h1}, 32'h0001_0500, rx);
    m_wip[1] = 8'hff;
    chk_wipers();
    run({qpd_pkg::OP_WR_WIPER, 4'h1}, 32'h0002, rx);
    run({qpd_pkg::OP_STEP, 4'h1}, 32'h0000_0500, rx);
    m_wip[1] = 8'h00;
    chk_wipers();
    d = 8'(1 + $urandom % 40);
    run({qpd_pkg::OP_STEP, 4'h1}, {15'h0, 1'b1, d, 8'h00}, rx);
    m_wip[1] = d;
    chk_wipers();
    rd(qpd_pkg::REG_DATA, w);
    chk_word(w, {15'h0, 1'b1, d, 8'h00});
    // Foreign address, then write protect
    wr(qpd_pkg::REG_CFG, 32'h1);
    run({qpd_pkg::OP_WR_WIPER, 4'h0}, {24'h0, ~m_wip[0]}, rx);
    wr(qpd_pkg::REG_CFG, 32'h2);
    chk_wipers();
    rd(qpd_pkg::REG_CFG, w);
    chk_word(w, 32'h2);
    wp_n <= 1'b0;
    run({qpd_pkg::OP_WR_STORE, 4'h0}, {24'h0, ~m_sto[0][0]}, rx);
    run(qpd_pkg::STATUS_INSTR, 32'h0, rx);
    chk_byte(rx, 8'h00);
    run({qpd_pkg::OP_RD_STORE, 4'h0}, 32'h0, rx);
    chk_byte(rx, m_sto[0][0]);
    wp_n <= 1'b1;
    // Undefined opcodes leave everything alone
    foreach (bad[i]) begin
      run({bad[i], 4'h1}, 32'h00a5, rx);
      chk_wipers();
    end
    // Status opcode with wrong low bits: output stays released high
    run({qpd_pkg::OP_STATUS, 4'h2}, 32'h0, rx);
    chk_byte(rx, 8'hff);
    chk_wipers();
    give_verdict();
  end
endmodule : quad_pot_spi_command_decoder_tb
